// [hdl/ogp_pkg.sv]
// shared constants, register map and field layouts of the pin configuration block
package ogp_pkg;

  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int EXT_CLK_HZ = 2_000_000;
  localparam int EXT_CLK_DIV = CLK_HZ / EXT_CLK_HZ;
  localparam int LONG_DEB_US = 10_000;
  localparam int LONG_DEB_CYC = LONG_DEB_US * (CLK_HZ / 1_000_000);

  // register indices; byte address is four times the index
  localparam logic [15:0] CFG_IDX = 16'h781f;
  localparam logic [15:0] STS_IDX = 16'h7f00;
  localparam logic [15:0] MSK_IDX = 16'h7f01;
  localparam logic [15:0] CTL_IDX = 16'h7f02;
  localparam int ADDR_W = 18;

  // configuration word reset value and field encodings
  localparam logic [15:0] CFG_RST = 16'ha400;
  localparam logic [15:0] CFG_WMASK = 16'hfff0;
  localparam logic [1:0] PULL_NONE = 2'h0;
  localparam logic [1:0] PULL_DOWN = 2'h1;
  localparam logic [1:0] PULL_UP = 2'h2;
  localparam logic DIR_OUT = 1'h0;
  localparam logic DIR_IN = 1'h1;

  // input function codes
  localparam logic [3:0] FI_GPI_LONG = 4'h0;
  localparam logic [3:0] FI_GPI = 4'h1;
  localparam logic [3:0] FI_ONOFF = 4'h2;
  localparam logic [3:0] FI_SLPWAKE = 4'h3;
  localparam logic [3:0] FI_SLPWAKE_LONG = 4'h4;
  localparam logic [3:0] FI_SLEEP = 4'h5;
  localparam logic [3:0] FI_PWRON = 4'h6;
  localparam logic [3:0] FI_WDOG = 4'h7;

  // output function codes
  localparam logic [3:0] FO_GPO = 4'h0;
  localparam logic [3:0] FO_OSC32K = 4'h1;
  localparam logic [3:0] FO_ON = 4'h2;
  localparam logic [3:0] FO_SLEEP = 4'h3;
  localparam logic [3:0] FO_PSCHG = 4'h4;
  localparam logic [3:0] FO_DVC1 = 4'h8;
  localparam logic [3:0] FO_DVC2 = 4'h9;
  localparam logic [3:0] FO_EXTEN1 = 4'ha;
  localparam logic [3:0] FO_EXTEN2 = 4'hb;
  localparam logic [3:0] FO_SSG = 4'hc;
  localparam logic [3:0] FO_CPG = 4'hd;
  localparam logic [3:0] FO_CLK2M = 4'he;
  localparam logic [3:0] FO_AUXRST = 4'hf;

  // interrupt status bits and control register bits
  localparam int EV_W = 2;
  localparam int EV_EDGE = 0;
  localparam int EV_REQ = 1;
  localparam int CTL_GPO = 0;
  localparam int CTL_LVL = 1;
  localparam int CTL_DEB = 2;

  // configuration word layout, msb first
  typedef struct packed {
    logic pin_direction;
    logic [1:0] pin_pull_select;
    logic pin_irq_edge_mode;
    logic pin_supply_domain;
    logic pin_polarity;
    logic pin_open_drain;
    logic pin_enable;
    logic [3:0] pin_function_select;
    logic [3:0] rsvd;
  } ogp_cfg_t;

  // state of the device that the pin may show in output direction
  typedef struct packed {
    logic on_state;
    logic sleep_state;
    logic power_state_change;
    logic dvc_done1;
    logic dvc_done2;
    logic ext_power_en1;
    logic ext_power_en2;
    logic system_supply_good;
    logic converter_power_good;
    logic aux_reset;
  } ogp_dev_t;

  // requests the pin raises in input direction
  typedef struct packed {
    logic gpio_level;
    logic power_onoff_req;
    logic sleep_wake_req;
    logic sleep_req;
    logic power_on_req;
    logic watchdog_reset;
  } ogp_req_t;

endpackage

// [hdl/ogp_sync_deb.sv]
// two-flop synchroniser with a long debounce filter behind it
`timescale 1ns/10ps
module ogp_sync_deb #(
  parameter int LONG_CYC = 500_000
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic din,
  output logic sync_out,
  output logic deb_out
);
  localparam int CW = $clog2(LONG_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(LONG_CYC - 1);

  logic meta_r;
  logic sync_r;
  logic deb_r;
  logic [CW-1:0] cnt_r;

  // only the second stage is read anywhere
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_r <= 1'h0;
      sync_r <= 1'h0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  // level must hold for the full count before the filtered copy follows
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
      deb_r <= 1'h0;
    end else if (sync_r == deb_r) begin
      cnt_r <= '0;
    end else if (cnt_r == LAST) begin
      cnt_r <= '0;
      deb_r <= sync_r;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end

  assign sync_out = sync_r;
  assign deb_out = deb_r;
endmodule

// [hdl/ogp_clk_div.sv]
// square wave divider: one period every DIV clocks
`timescale 1ns/10ps
module ogp_clk_div #(
  parameter int DIV = 25
) (
  input wire logic ref_clk,
  input wire logic rst,
  output logic clk_out
);
  localparam int CW = $clog2(DIV);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  localparam logic [CW-1:0] HALF = CW'(DIV / 2);

  logic [CW-1:0] cnt_r;
  logic out_r;

  // odd divisors give a slightly short high phase
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= '0;
      out_r <= 1'h0;
    end else begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
      out_r <= (cnt_r < HALF);
    end
  end

  assign clk_out = out_r;
endmodule

// [hdl/ogp_pin_cfg.sv]
// configurable general-purpose pin with avalon register access
//
// Function
// R1: enable off tri-states; direction bit selects in/out
// R2: pull select: none, down, up; 11 reserved
// R3: edge mode 0: edge into active level
// R4: edge mode 1: interrupt on both edges
// R5: polarity 1 active high, 0 active low
// R6: driver type push-pull or open drain
// R7: store supply domain select, digital or main
// R8: input codes 0/1 general input, long/short debounce; code 1 takes the synchronised level with no debounce filter
// R9: input codes 2-4 power and sleep requests
// R10: input codes 5-7 sleep, power on, watchdog
// R11: output codes 2-4 state indications; 5-7 reserved
// R12: output codes 8-11 change done, power enables
// R13: output codes 12-15 supply good, clock, reset
// R14: output codes 0 plain output, 1 osc clock
// R15: direction picks input or output function table
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/10ps
module ogp_pin_cfg #(
  parameter int LONG_DEB_CYC = ogp_pkg::LONG_DEB_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [ogp_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  output logic pin_pull_up_en,
  output logic pin_pull_down_en,
  output logic pin_supply_sel,
  output logic pin_od_mode,
  // device side
  input wire logic osc_32k,
  input wire ogp_pkg::ogp_dev_t dev_state,
  output ogp_pkg::ogp_req_t pin_req,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // register storage

  logic [15:0] cfg_r;
  logic [ogp_pkg::EV_W-1:0] sts_r;
  logic [ogp_pkg::EV_W-1:0] sts_nxt;
  logic [ogp_pkg::EV_W-1:0] msk_r;
  logic gpo_r;
  logic [31:0] rdata_r;
  logic wait_r;
  logic irq_r;
  ogp_pkg::ogp_cfg_t cfg;

  assign cfg = ogp_pkg::ogp_cfg_t'(cfg_r);

  ////////////////////////////////////////////////////////////////////////
  // bus decode

  logic req;
  logic take;
  logic hit_cfg;
  logic hit_sts;
  logic hit_msk;
  logic hit_ctl;

  assign req = avs_read | avs_write;
  // the request is completed on the edge where waitrequest is seen low
  assign take = req & ~wait_r;
  assign hit_cfg = (avs_address == {ogp_pkg::CFG_IDX, 2'h0});
  assign hit_sts = (avs_address == {ogp_pkg::STS_IDX, 2'h0});
  assign hit_msk = (avs_address == {ogp_pkg::MSK_IDX, 2'h0});
  assign hit_ctl = (avs_address == {ogp_pkg::CTL_IDX, 2'h0});

  ////////////////////////////////////////////////////////////////////////
  // pin sampling and clock sources

  logic pin_sync;
  logic pin_deb;
  logic osc_meta_r;
  logic osc_sync_r;
  logic clk2m;

  ogp_sync_deb #(
    .LONG_CYC(LONG_DEB_CYC)
  ) u_pin_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .din(pin_in),
    .sync_out(pin_sync),
    .deb_out(pin_deb)
  );

  ogp_clk_div #(
    .DIV(ogp_pkg::EXT_CLK_DIV)
  ) u_clk2m (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_out(clk2m)
  );

  // the oscillator clock is foreign to ref_clk, so it is resynchronised
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      osc_meta_r <= 1'h0;
      osc_sync_r <= 1'h0;
    end else begin
      osc_meta_r <= osc_32k;
      osc_sync_r <= osc_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // active levels seen at the pin

  logic act_lvl;
  logic act_deb;
  logic act_prev_r;
  logic rise;
  logic fall;
  logic edge_ev;
  logic is_in;

  assign is_in = cfg.pin_enable & (cfg.pin_direction == ogp_pkg::DIR_IN); // R1
  assign act_lvl = cfg.pin_polarity ? pin_sync : ~pin_sync; // R5
  assign act_deb = cfg.pin_polarity ? pin_deb : ~pin_deb; // R5

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      act_prev_r <= 1'h0;
    end else begin
      act_prev_r <= act_lvl;
    end
  end

  // edges are taken on the active level, so polarity turns rising into falling
  assign rise = act_lvl & ~act_prev_r;
  assign fall = ~act_lvl & act_prev_r;
  always_comb begin
    if (cfg.pin_irq_edge_mode) begin
      edge_ev = is_in & (rise | fall); // R4
    end else begin
      edge_ev = is_in & rise; // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // input function table

  ogp_pkg::ogp_req_t req_nxt;
  ogp_pkg::ogp_req_t req_r;

  // codes 8..15 drive inputs of other blocks and raise nothing here
  always_comb begin
    req_nxt = '0;
    if (is_in) begin // R15
      case (cfg.pin_function_select)
        ogp_pkg::FI_GPI_LONG: req_nxt.gpio_level = act_deb; // R8
        ogp_pkg::FI_GPI: req_nxt.gpio_level = act_lvl; // R8
        ogp_pkg::FI_ONOFF: req_nxt.power_onoff_req = act_lvl; // R9
        ogp_pkg::FI_SLPWAKE: req_nxt.sleep_wake_req = act_lvl; // R9
        ogp_pkg::FI_SLPWAKE_LONG: req_nxt.sleep_wake_req = act_deb; // R9
        ogp_pkg::FI_SLEEP: req_nxt.sleep_req = act_lvl; // R10
        ogp_pkg::FI_PWRON: req_nxt.power_on_req = act_lvl; // R10
        ogp_pkg::FI_WDOG: req_nxt.watchdog_reset = act_lvl; // R10
        default: req_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_r <= '0;
    end else begin
      req_r <= req_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output function table

  logic src;
  logic lvl;

  always_comb begin
    case (cfg.pin_function_select)
      ogp_pkg::FO_GPO: src = gpo_r; // R14
      ogp_pkg::FO_OSC32K: src = osc_sync_r; // R14
      ogp_pkg::FO_ON: src = dev_state.on_state; // R11
      ogp_pkg::FO_SLEEP: src = dev_state.sleep_state; // R11
      ogp_pkg::FO_PSCHG: src = dev_state.power_state_change; // R11
      ogp_pkg::FO_DVC1: src = dev_state.dvc_done1; // R12
      ogp_pkg::FO_DVC2: src = dev_state.dvc_done2; // R12
      ogp_pkg::FO_EXTEN1: src = dev_state.ext_power_en1; // R12
      ogp_pkg::FO_EXTEN2: src = dev_state.ext_power_en2; // R12
      ogp_pkg::FO_SSG: src = dev_state.system_supply_good; // R13
      ogp_pkg::FO_CPG: src = dev_state.converter_power_good; // R13
      ogp_pkg::FO_CLK2M: src = clk2m; // R13
      ogp_pkg::FO_AUXRST: src = dev_state.aux_reset; // R13
      default: src = 1'h0; // R11
    endcase
  end

  // inverted polarity drives the inactive level as high
  assign lvl = cfg.pin_polarity ? src : ~src; // R5

  ////////////////////////////////////////////////////////////////////////
  // pin drivers

  logic pin_out_r;
  logic pin_oe_r;
  logic pu_r;
  logic pd_r;
  logic dom_r;
  logic od_r;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_out_r <= 1'h0;
      pin_oe_r <= 1'h0;
    end else if (!cfg.pin_enable || cfg.pin_direction == ogp_pkg::DIR_IN) begin
      pin_out_r <= 1'h0; // R1
      pin_oe_r <= 1'h0; // R1
    end else if (cfg.pin_open_drain) begin
      pin_out_r <= 1'h0; // R6
      pin_oe_r <= ~lvl; // R6
    end else begin
      pin_out_r <= lvl; // R6
      pin_oe_r <= 1'h1; // R15
    end
  end

  // reserved pull code falls back to no pull rather than fighting itself
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pu_r <= 1'h0;
      pd_r <= 1'h0;
      dom_r <= 1'h0;
      od_r <= 1'h0;
    end else begin
      pu_r <= (cfg.pin_pull_select == ogp_pkg::PULL_UP); // R2
      pd_r <= (cfg.pin_pull_select == ogp_pkg::PULL_DOWN); // R2
      dom_r <= cfg.pin_supply_domain; // R7
      od_r <= cfg.pin_open_drain; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register writes

  // bits 3:0 of the configuration word are reserved and stay zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cfg_r <= ogp_pkg::CFG_RST;
    end else if (take && avs_write && hit_cfg) begin
      if (avs_byteenable[0]) begin
        cfg_r[7:0] <= avs_writedata[7:0] & ogp_pkg::CFG_WMASK[7:0];
      end
      if (avs_byteenable[1]) begin
        cfg_r[15:8] <= avs_writedata[15:8];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      msk_r <= '0;
      gpo_r <= 1'h0;
    end else if (take && avs_write && avs_byteenable[0]) begin
      if (hit_msk) begin
        msk_r <= avs_writedata[ogp_pkg::EV_W-1:0];
      end
      if (hit_ctl) begin
        gpo_r <= avs_writedata[ogp_pkg::CTL_GPO];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // interrupt status: write one to clear, a new event wins over the clear

  logic [ogp_pkg::EV_W-1:0] ev;
  logic [ogp_pkg::EV_W-1:0] clr;

  assign ev[ogp_pkg::EV_EDGE] = edge_ev;
  assign ev[ogp_pkg::EV_REQ] = (|req_nxt) & ~(|req_r);
  assign clr = (take && avs_write && hit_sts && avs_byteenable[0]) ?
               avs_writedata[ogp_pkg::EV_W-1:0] : '0;
  assign sts_nxt = (sts_r & ~clr) | ev;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sts_r <= '0;
      irq_r <= 1'h0;
    end else begin
      sts_r <= sts_nxt;
      irq_r <= |(sts_nxt & msk_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus answer: one wait cycle, read data captured with it

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_r <= 1'h1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  // unmapped addresses read zero and ignore writes
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_r <= '0;
    end else if (req && wait_r) begin
      rdata_r <= '0;
      if (hit_cfg) begin
        rdata_r[15:0] <= cfg_r;
      end
      if (hit_sts) begin
        rdata_r[ogp_pkg::EV_W-1:0] <= sts_r;
      end
      if (hit_msk) begin
        rdata_r[ogp_pkg::EV_W-1:0] <= msk_r;
      end
      if (hit_ctl) begin
        rdata_r[ogp_pkg::CTL_GPO] <= gpo_r;
        rdata_r[ogp_pkg::CTL_LVL] <= act_lvl;
        rdata_r[ogp_pkg::CTL_DEB] <= act_deb;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign avs_readdata = rdata_r;
  assign avs_waitrequest = wait_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pin_pull_up_en = pu_r;
  assign pin_pull_down_en = pd_r;
  assign pin_supply_sel = dom_r;
  assign pin_od_mode = od_r;
  assign pin_req = req_r;
  assign irq = irq_r;

endmodule

// [tb/ogp_pin_host.sv]
// board-side model of the pin: resolves the wire from every party's drive
`timescale 1ns/10ps
module ogp_pin_host (
  input wire logic ref_clk,
  input wire logic ext_drive,
  input wire logic ext_level,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic pin_pull_up_en,
  input wire logic pin_pull_down_en,
  output logic pin_in
);
  logic alt_r = 1'b0;
  // a floating wire toggles each cycle so no stale level is mistaken for a drive
  always @(posedge ref_clk) alt_r <= ~alt_r;
  // device drive wins, then the board, then the pull, then float
  assign pin_in = pin_oe ? pin_out : ext_drive ? ext_level :
                  pin_pull_up_en ? 1'b1 : pin_pull_down_en ? 1'b0 : alt_r;
endmodule

// [tb/ogp_pin_cfg_sva.sv]
// port-level checks of the pin configuration block
`timescale 1ns/10ps
module ogp_pin_cfg_sva (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic pin_out,
  input wire logic pin_oe,
  input wire logic pin_pull_up_en,
  input wire logic pin_pull_down_en,
  input wire logic pin_od_mode,
  input wire ogp_pkg::ogp_req_t pin_req,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  property p_pull_excl; !(pin_pull_up_en && pin_pull_down_en); endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("both pulls on");
  property p_od_low; pin_oe && pin_od_mode |-> !pin_out; endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drives high");
  // three cycles of output drive give the request logic time to settle
  property p_out_no_req; pin_oe && $past(pin_oe) && $past(pin_oe, 2) |-> pin_req == '0; endproperty
  a_out_no_req: assert property (p_out_no_req) else $error("request raised in output direction");
  property p_req_excl; $onehot0(pin_req[4:0]); endproperty
  a_req_excl: assert property (p_req_excl) else $error("two input functions at once");
  property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("access not answered after one wait");
  property p_wait_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("answer held over two cycles");
  property p_no_spont; !(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest; endproperty
  a_no_spont: assert property (p_no_spont) else $error("answer without request");
  property p_rst; disable iff (1'b0) rst |=> avs_waitrequest && !pin_oe && !irq && pin_req == '0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not quiet in reset");
  c_irq: cover property ($rose(irq));
  c_drive: cover property ($rose(pin_oe));
  c_write: cover property (avs_write && !avs_waitrequest);
endmodule
bind ogp_pin_cfg ogp_pin_cfg_sva i_sva (.ref_clk(ref_clk), .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up_en(pin_pull_up_en),
  .pin_pull_down_en(pin_pull_down_en), .pin_od_mode(pin_od_mode), .pin_req(pin_req), .irq(irq));

// [tb/ogp_pin_cfg_bench.sv]
// self-checking bench: register accesses, output table, input edges and requests
`timescale 1ns/10ps
module ogp_pin_cfg_bench;
  localparam int DEB = 8;
  localparam int OCODE[10] = '{2, 3, 4, 8, 9, 10, 11, 12, 13, 15};
  localparam int RQ[6] = '{16, 8, 8, 4, 2, 1};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [ogp_pkg::ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic pin_in, pin_out, pin_oe, pin_pull_up_en, pin_pull_down_en, pin_supply_sel, pin_od_mode, irq;
  logic osc_32k = 1'b0;
  logic ext_drive = 1'b0;
  logic ext_level = 1'b0;
  ogp_pkg::ogp_dev_t dev_state = '0;
  ogp_pkg::ogp_req_t pin_req;
  logic [31:0] rdv;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int k, hi;
  ogp_pin_cfg #(.LONG_DEB_CYC(DEB)) i_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up_en(pin_pull_up_en), .pin_pull_down_en(pin_pull_down_en),
    .pin_supply_sel(pin_supply_sel), .pin_od_mode(pin_od_mode), .osc_32k(osc_32k),
    .dev_state(dev_state), .pin_req(pin_req), .irq(irq));
  ogp_pin_host i_host (.ref_clk(ref_clk), .ext_drive(ext_drive), .ext_level(ext_level), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pull_up_en(pin_pull_up_en), .pin_pull_down_en(pin_pull_down_en), .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////
  always #10 ref_clk = ~ref_clk;
  // a hang is cut short well past the expected run length
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one bus access; the request holds until a rising edge samples waitrequest low, data are taken there
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge ref_clk);
    avs_address <= {idx, 2'h0};
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= wd;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] exp, input string nm);
    bus(1'b0, idx, '0);
    chk(nm, rdv, exp);
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  function automatic logic [31:0] cw(input logic dir, input logic [1:0] pl, input logic md, input logic sp,
                                     input logic pol, input logic od, input logic en, input logic [3:0] fn);
    return {16'h0, dir, pl, md, sp, pol, od, en, fn, 4'h0};
  endfunction
  // clear status, move the board level, then look at the interrupt line
  task automatic edge_irq(input logic lvl, input logic exp);
    bus(1'b1, ogp_pkg::STS_IDX, 32'h3);
    @(posedge ref_clk) ext_level <= lvl;
    tick(6);
    chk("irq", irq, exp);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    // the releasing edge still sees reset, so the pull copy follows one edge later
    tick(2);
    chk("pull_down", pin_pull_down_en, 1);
    chk("oe", pin_oe, 0);
    rdc(ogp_pkg::CFG_IDX, 32'ha400, "cfg");
    rdc(16'h1234, 32'h0, "unmapped");
    rdc(ogp_pkg::MSK_IDX, 32'h0, "mask");
    bus(1'b1, ogp_pkg::CFG_IDX, 32'hffff);
    rdc(ogp_pkg::CFG_IDX, 32'hfff0, "cfg_rw");
    for (k = 0; k < 4; k++) begin
      bus(1'b1, ogp_pkg::CFG_IDX, cw(1, k[1:0], 0, 0, 1, 0, 0, 0));
      tick(2);
      chk("pull_up", pin_pull_up_en, k == 2);
      chk("pull_down", pin_pull_down_en, k == 1);
    end
    bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 1, 0, 1, 1, 1, 0, 0));
    tick(2);
    chk("supply", pin_supply_sel, 1);
    chk("od", pin_od_mode, 1);
    // each output code must follow its own device level and no other
    for (k = 0; k < 10; k++) begin
      bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 1, 0, 1, OCODE[k][3:0]));
      @(posedge ref_clk) dev_state <= 10'h1 << (9 - k);
      tick(2);
      chk("oe", pin_oe, 1);
      chk("out_hi", pin_out, 1);
      @(posedge ref_clk) dev_state <= ~(10'h1 << (9 - k));
      tick(2);
      chk("out_lo", pin_out, 0);
    end
    for (k = 5; k < 8; k++) begin
      bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 1, 0, 1, k[3:0]));
      tick(2);
      chk("reserved", pin_out, 0);
    end
    bus(1'b1, ogp_pkg::CTL_IDX, 32'h1);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 1, 0, 1, 0));
    tick(2);
    chk("gpo", pin_out, 1);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 0, 0, 1, 0));
    tick(2);
    chk("gpo_inv", pin_out, 0);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 1, 1, 1, 0));
    tick(2);
    chk("od_release", pin_oe, 0);
    bus(1'b1, ogp_pkg::CTL_IDX, 32'h0);
    tick(2);
    chk("od_sink", pin_oe, 1);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 1, 0, 0, 0));
    tick(2);
    chk("disabled", pin_oe, 0);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 1, 0, 1, 1));
    @(posedge ref_clk) osc_32k <= 1'b1;
    tick(5);
    chk("osc_hi", pin_out, 1);
    @(posedge ref_clk) osc_32k <= 1'b0;
    tick(5);
    chk("osc_lo", pin_out, 0);
    // two whole periods of the divided clock hold exactly 24 high cycles
    bus(1'b1, ogp_pkg::CFG_IDX, cw(0, 0, 0, 0, 1, 0, 1, 14));
    tick(1);
    hi = 0;
    repeat (50) begin
      @(negedge ref_clk) hi += (pin_out === 1'b1);
    end
    chk("clk2m_high", hi, 24);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 0, 0, 0, 1, 0, 1, 1));
    @(posedge ref_clk) ext_drive <= 1'b1;
    bus(1'b1, ogp_pkg::MSK_IDX, 32'h1);
    edge_irq(1, 1);
    edge_irq(0, 0);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 0, 1, 0, 1, 0, 1, 1));
    edge_irq(1, 1);
    edge_irq(0, 1);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 0, 0, 0, 0, 0, 1, 1));
    edge_irq(1, 0);
    edge_irq(0, 1);
    bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 0, 1, 0, 1, 0, 1, 1));
    bus(1'b1, ogp_pkg::MSK_IDX, 32'h0);
    edge_irq(1, 0);
    bus(1'b1, ogp_pkg::MSK_IDX, 32'h1);
    tick(3);
    chk("irq_sticky", irq, 1);
    @(posedge ref_clk) ext_level <= 1'b0;
    for (k = 2; k < 8; k++) begin
      bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 0, 0, 0, 1, 0, 1, k[3:0]));
      @(posedge ref_clk) ext_level <= 1'b1;
      tick(DEB + 8);
      chk("request", pin_req[4:0], RQ[k - 2]);
      @(posedge ref_clk) ext_level <= 1'b0;
      tick(DEB + 8);
    end
    // both events have fired by now; a written one clears them
    rdc(ogp_pkg::STS_IDX, 32'h3, "status");
    bus(1'b1, ogp_pkg::STS_IDX, 32'h3);
    rdc(ogp_pkg::STS_IDX, 32'h0, "status_w1c");
    // a pulse shorter than the long filter must not reach the level
    bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 0, 0, 0, 1, 0, 1, 0));
    @(posedge ref_clk) ext_level <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ext_level <= 1'b0;
    tick(DEB + 8);
    chk("long_glitch", pin_req.gpio_level, 0);
    @(posedge ref_clk) ext_level <= 1'b1;
    tick(DEB + 8);
    chk("long_level", pin_req.gpio_level, 1);
    rdc(ogp_pkg::CTL_IDX, 32'h6, "ctl_levels");
    bus(1'b1, ogp_pkg::CFG_IDX, cw(1, 0, 0, 0, 1, 0, 1, 1));
    @(posedge ref_clk) ext_level <= 1'b0;
    tick(5);
    chk("short_level", pin_req.gpio_level, 0);
    print_verdict();
  end
endmodule
